// ===== pwc_pkg.sv
package pwc_pkg;

   // Register bus shape
   localparam int          BUS_DATA_W     = 32;
   localparam int          ADDR_W         = 7;
   localparam int          REG_W          = 8;
   localparam int          NUM_CH         = 4;
   localparam int          WIDE_W         = 16;
   localparam int          PRESC_W        = 7;

   // Word indices of the registers
   localparam logic [6:0]  OFF_CLK        = 7'h40;
   localparam logic [6:0]  OFF_POL        = 7'h41;
   localparam logic [6:0]  OFF_EN         = 7'h42;
   localparam logic [6:0]  OFF_PRESC      = 7'h43;
   localparam logic [6:0]  OFF_SCALE0     = 7'h44;
   localparam logic [6:0]  OFF_SCNT0      = 7'h45;
   localparam logic [6:0]  OFF_SCALE1     = 7'h46;
   localparam logic [6:0]  OFF_SCNT1      = 7'h47;
   localparam logic [6:0]  OFF_CNT0       = 7'h48;
   localparam logic [6:0]  OFF_PER0       = 7'h4C;
   localparam logic [6:0]  OFF_DUTY0      = 7'h50;
   localparam logic [6:0]  OFF_ALIGN      = 7'h54;

   // Field positions in clock_prescale_and_pairing
   localparam int          JOIN_UPPER_BIT = 7;
   localparam int          JOIN_LOWER_BIT = 6;
   localparam int          DIV_A_LSB      = 3;
   localparam int          DIV_B_LSB      = 0;
   localparam int          DIV_W          = 3;

   // Field positions in clock_select_and_polarity
   localparam int          SEL_LSB        = 4;
   localparam int          SENSE_LSB      = 0;

   // Reset values
   localparam logic [7:0]  CLK_RESET      = 8'h00;
   localparam logic [7:0]  POL_RESET      = 8'h00;
   localparam logic [7:0]  PER_RESET      = 8'hFF;
   localparam logic [7:0]  DUTY_RESET     = 8'hFF;
   localparam logic [7:0]  BYTE_ZERO      = 8'h00;

   // Bus answer sequencer
   typedef enum logic [0:0] {
      BUS_IDLE   = 1'b0,
      BUS_ANSWER = 1'b1
   } pwc_bus_state_type;

endpackage : pwc_pkg

// ===== pwc_channel.sv
`timescale 1ns/1ps

module pwc_channel #(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   // Control
   input  wire logic             tick,
   input  wire logic             enable,
   input  wire logic             center,
   input  wire logic             sense,
   input  wire logic             clearCount,
   input  wire logic [CNT_W-1:0] perBuf,
   input  wire logic [CNT_W-1:0] dutyBuf,
   // Status and waveform
   output logic      [CNT_W-1:0] count,
   output logic                  wave
);
   import pwc_pkg::*;

   logic [CNT_W-1:0] activePer;
   logic [CNT_W-1:0] activeDuty;
   logic             down;
   logic [CNT_W-1:0] next_activePer;
   logic [CNT_W-1:0] next_activeDuty;
   logic [CNT_W-1:0] next_count;
   logic             next_down;
   logic             next_wave;
   logic             rollover;
   logic             lastStep;

   ////////////////////////////////////////////////////////////////////////////
   // Counter, active latches and output compare
   always_comb begin
      next_activePer  = activePer;
      next_activeDuty = activeDuty;
      next_count      = count;
      next_down       = down;
      rollover        = 1'b0;
      lastStep        = (activePer == '0) || (count >= activePer - CNT_W'(1));
      if (clearCount) begin
         next_count      = '0;
         next_down       = 1'b0;
         next_activePer  = perBuf;
         next_activeDuty = dutyBuf;
      end else if (!enable) begin
         // Stopped: writes go straight to the latches
         next_activePer  = perBuf;
         next_activeDuty = dutyBuf;
      end else if (tick) begin
         if (!center) begin
            // Left aligned: 0 .. period-1 then wrap
            if (lastStep) begin
               next_count = '0;
               rollover   = 1'b1;
            end else begin
               next_count = count + CNT_W'(1);
            end
         end else if (!down) begin
            // Centre: period match turns round
            if (activePer == '0) begin
               rollover = 1'b1;
            end else if (count >= activePer) begin
               next_down  = 1'b1;
               next_count = count - CNT_W'(1);
            end else begin
               next_count = count + CNT_W'(1);
            end
         end else if (count == '0) begin
            next_down  = 1'b0;
            next_count = CNT_W'(1);
            rollover   = 1'b1;
         end else begin
            next_count = count - CNT_W'(1);
         end
         // Buffered values load at a period boundary
         if (rollover) begin
            next_activePer  = perBuf;
            next_activeDuty = dutyBuf;
         end
      end
      // Start of period shows the sense level, duty match flips it
      next_wave = (count < activeDuty) ? sense : ~sense;
   end

   // Channel state registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         activePer  <= '1;
         activeDuty <= '1;
         count      <= '0;
         down       <= 1'b0;
         wave       <= 1'b0;
      end else begin
         activePer  <= next_activePer;
         activeDuty <= next_activeDuty;
         count      <= next_count;
         down       <= next_down;
         wave       <= next_wave;
      end
   end

endmodule : pwc_channel

// ===== pwc_top.sv
// Behaviour
// - Four 8-bit channels, or pairs joined into 16-bit units, per pairing bits.
// - Each channel has period, duty and counter; duty spans 0 to 100 percent.
// - Each channel runs left aligned or centre aligned.
// - While running, new period and duty wait in a buffer until rollover.
// - While stopped, period and duty writes reach buffer and active latch at once.
// - Counter write clears the counter and loads buffered period and duty.
// - Software can read every channel counter.
// - Enabled channel owns its port pin; otherwise the pin stays general I/O. Joined pairs here drive the even pin by the odd enable.
// - Upper pairing: ch2 high, ch3 low, ch3 clock, output on ch2 pin.
// - Lower pairing: ch0 high, ch1 low, ch1 clock, output on ch0 pin.
// - Three-bit field divides base clock by two to the field for clock A.
// - Second three-bit field sets clock B with the same encoding.
// - Channels 2 and 3 pick clock B when select clear, S1 when set.
// - Channels 0 and 1 pick clock A when select clear, S0 when set.
// - Switching a clock select mid-waveform may give one odd pulse.
// - Select bits 7 to 4, sense bits 3 to 0, all cleared at reset.
// - Sense clear: low at period start, high at duty match; set: inverse.
// - Scaled clock is clock A or B divided by scale plus one, then by two.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps

module pwc_top (
   // Clock and reset
   input  wire logic                                 clk_sys,
   input  wire logic                                 reset_n,
   // Avalon-MM slave
   input  wire logic [pwc_pkg::ADDR_W-1:0]           address,
   input  wire logic                                 read,
   input  wire logic                                 write,
   input  wire logic [pwc_pkg::BUS_DATA_W-1:0]       writedata,
   input  wire logic [3:0]                           byteenable,
   output logic      [pwc_pkg::BUS_DATA_W-1:0]       readdata,
   output logic                                      waitrequest,
   // General-purpose port
   input  wire logic [pwc_pkg::NUM_CH-1:0]           gpioOut,
   input  wire logic [pwc_pkg::NUM_CH-1:0]           gpioDir,
   // Port pins
   output logic      [pwc_pkg::NUM_CH-1:0]           pinOut,
   output logic      [pwc_pkg::NUM_CH-1:0]           pinOe
);
   import pwc_pkg::*;

   pwc_bus_state_type        busState;
   pwc_bus_state_type        next_busState;
   logic [BUS_DATA_W-1:0]    next_readdata;
   logic [REG_W-1:0]         readValue;
   logic                     accept;
   logic                     wrLow;

   logic [REG_W-1:0]         clkReg;
   logic [REG_W-1:0]         polReg;
   logic [NUM_CH-1:0]        enReg;
   logic [NUM_CH-1:0]        alignReg;
   logic [REG_W-1:0]         scaleReg  [2];
   logic [REG_W-1:0]         perReg    [NUM_CH];
   logic [REG_W-1:0]         dutyReg   [NUM_CH];
   logic [REG_W-1:0]         next_clkReg;
   logic [REG_W-1:0]         next_polReg;
   logic [NUM_CH-1:0]        next_enReg;
   logic [NUM_CH-1:0]        next_alignReg;
   logic [REG_W-1:0]         next_scaleReg [2];
   logic [REG_W-1:0]         next_perReg   [NUM_CH];
   logic [REG_W-1:0]         next_dutyReg  [NUM_CH];
   logic [NUM_CH-1:0]        cntClear;
   logic [1:0]               scaleLoad;

   logic [PRESC_W-1:0]       presc;
   logic [PRESC_W-1:0]       next_presc;
   logic [REG_W-1:0]         scnt      [2];
   logic [REG_W-1:0]         next_scnt [2];
   logic [1:0]               half;
   logic [1:0]               next_half;
   logic [PRESC_W-1:0]       divMask   [2];
   logic [DIV_W-1:0]         divField  [2];
   logic [1:0]               baseTick;
   logic [1:0]               scaledTick;
   logic                     anyEn;

   logic [WIDE_W-1:0]        unitCnt   [NUM_CH];
   logic [NUM_CH-1:0]        unitWave;
   logic [REG_W-1:0]         chCount   [NUM_CH];
   logic [NUM_CH-1:0]        drive;
   logic [NUM_CH-1:0]        driveVal;
   logic [NUM_CH-1:0]        next_pinOut;
   logic [NUM_CH-1:0]        next_pinOe;

   ////////////////////////////////////////////////////////////////////////////
   // Bus sequencer: one wait cycle, then the answer edge
   assign waitrequest = (read | write) & (busState == BUS_IDLE);
   assign accept      = (read | write) & (busState == BUS_ANSWER);
   assign wrLow       = accept & write & byteenable[0];

   always_comb begin
      next_busState = busState;
      next_readdata = readdata;
      case (busState)
         BUS_IDLE: begin
            if (read | write) begin
               next_busState = BUS_ANSWER;
               // Captured a cycle early so it stands at the answer edge
               next_readdata = {{(BUS_DATA_W-REG_W){1'b0}}, readValue};
            end
         end
         BUS_ANSWER: begin
            next_busState = BUS_IDLE;
         end
         default: begin
            next_busState = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busState <= BUS_IDLE;
         readdata <= '0;
      end else begin
         busState <= next_busState;
         readdata <= next_readdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode; unmapped indices read as zero
   always_comb begin
      readValue = BYTE_ZERO;
      if (address == OFF_CLK) begin
         readValue = clkReg;
      end else if (address == OFF_POL) begin
         readValue = polReg;
      end else if (address == OFF_EN) begin
         readValue = {{(REG_W-NUM_CH){1'b0}}, enReg};
      end else if (address == OFF_PRESC) begin
         readValue = {1'b0, presc};
      end else if (address == OFF_SCALE0) begin
         readValue = scaleReg[0];
      end else if (address == OFF_SCNT0) begin
         readValue = scnt[0];
      end else if (address == OFF_SCALE1) begin
         readValue = scaleReg[1];
      end else if (address == OFF_SCNT1) begin
         readValue = scnt[1];
      end else if (address >= OFF_CNT0 && address < OFF_PER0) begin
         readValue = chCount[2'(address - OFF_CNT0)];
      end else if (address >= OFF_PER0 && address < OFF_DUTY0) begin
         readValue = perReg[2'(address - OFF_PER0)];
      end else if (address >= OFF_DUTY0 && address < OFF_ALIGN) begin
         readValue = dutyReg[2'(address - OFF_DUTY0)];
      end else if (address == OFF_ALIGN) begin
         readValue = {{(REG_W-NUM_CH){1'b0}}, alignReg};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and their side-effect pulses
   always_comb begin
      next_clkReg   = clkReg;
      next_polReg   = polReg;
      next_enReg    = enReg;
      next_alignReg = alignReg;
      next_scaleReg = scaleReg;
      next_perReg   = perReg;
      next_dutyReg  = dutyReg;
      cntClear      = '0;
      scaleLoad     = '0;
      if (wrLow) begin
         if (address == OFF_CLK) begin
            next_clkReg = writedata[REG_W-1:0];
         end else if (address == OFF_POL) begin
            next_polReg = writedata[REG_W-1:0];
         end else if (address == OFF_EN) begin
            next_enReg = writedata[NUM_CH-1:0];
         end else if (address == OFF_SCALE0) begin
            next_scaleReg[0] = writedata[REG_W-1:0];
            scaleLoad[0]     = 1'b1;
         end else if (address == OFF_SCALE1) begin
            next_scaleReg[1] = writedata[REG_W-1:0];
            scaleLoad[1]     = 1'b1;
         end else if (address >= OFF_CNT0 && address < OFF_PER0) begin
            cntClear[2'(address - OFF_CNT0)] = 1'b1;
         end else if (address >= OFF_PER0 && address < OFF_DUTY0) begin
            next_perReg[2'(address - OFF_PER0)] = writedata[REG_W-1:0];
         end else if (address >= OFF_DUTY0 && address < OFF_ALIGN) begin
            next_dutyReg[2'(address - OFF_DUTY0)] = writedata[REG_W-1:0];
         end else if (address == OFF_ALIGN) begin
            next_alignReg = writedata[NUM_CH-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         clkReg   <= CLK_RESET;
         polReg   <= POL_RESET;
         enReg    <= '0;
         alignReg <= '0;
         for (int i = 0; i < 2; i++) begin
            scaleReg[i] <= BYTE_ZERO;
         end
         for (int i = 0; i < NUM_CH; i++) begin
            perReg[i]  <= PER_RESET;
            dutyReg[i] <= DUTY_RESET;
         end
      end else begin
         clkReg   <= next_clkReg;
         polReg   <= next_polReg;
         enReg    <= next_enReg;
         alignReg <= next_alignReg;
         scaleReg <= next_scaleReg;
         perReg   <= next_perReg;
         dutyReg  <= next_dutyReg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler and two scalers; all rates are enables
   assign anyEn       = |enReg;
   assign divField[0] = clkReg[DIV_A_LSB +: DIV_W];
   assign divField[1] = clkReg[DIV_B_LSB +: DIV_W];

   always_comb begin
      // Holding the count when idle saves toggling, like a gated prescaler
      next_presc = anyEn ? presc + PRESC_W'(1) : presc;
      next_scnt  = scnt;
      next_half  = half;
      for (int p = 0; p < 2; p++) begin
         // Low field bits all ones gives a pulse every 2**field cycles
         divMask[p]    = PRESC_W'((8'h01 << divField[p]) - 8'h01);
         baseTick[p]   = anyEn && ((presc & divMask[p]) == divMask[p]);
         scaledTick[p] = baseTick[p] && (scnt[p] == BYTE_ZERO) && half[p];
         if (scaleLoad[p]) begin
            next_scnt[p] = next_scaleReg[p];
         end else if (baseTick[p]) begin
            if (scnt[p] == BYTE_ZERO) begin
               next_scnt[p] = scaleReg[p];
               next_half[p] = ~half[p];
            end else begin
               next_scnt[p] = scnt[p] - 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         presc   <= '0;
         scnt[0] <= BYTE_ZERO;
         scnt[1] <= BYTE_ZERO;
         half    <= '0;
      end else begin
         presc <= next_presc;
         scnt  <= next_scnt;
         half  <= next_half;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel pairs: even channel is the high byte, odd the low byte
   for (genvar p = 0; p < 2; p++) begin : gPair
      localparam int HI = 2 * p;
      localparam int LO = 2 * p + 1;
      logic joined;
      logic hiTick;
      logic loTick;

      assign joined = clkReg[(p == 0) ? JOIN_LOWER_BIT : JOIN_UPPER_BIT];
      // Select swaps mid-waveform are not synchronised to a period edge
      assign hiTick = polReg[SEL_LSB+HI] ? scaledTick[p] : baseTick[p];
      assign loTick = polReg[SEL_LSB+LO] ? scaledTick[p] : baseTick[p];

      // Low unit runs the joined channel on its own clock
      pwc_channel #(.CNT_W(WIDE_W)) uLow (
         .clk_sys    (clk_sys),
         .reset_n    (reset_n),
         .tick       (loTick),
         .enable     (enReg[LO]),
         .center     (alignReg[LO]),
         .sense      (joined ? polReg[SENSE_LSB+HI] : polReg[SENSE_LSB+LO]),
         .clearCount (cntClear[LO] | (joined & cntClear[HI])),
         .perBuf     (joined ? {perReg[HI], perReg[LO]} : {BYTE_ZERO, perReg[LO]}),
         .dutyBuf    (joined ? {dutyReg[HI], dutyReg[LO]} : {BYTE_ZERO, dutyReg[LO]}),
         .count      (unitCnt[LO]),
         .wave       (unitWave[LO])
      );

      pwc_channel #(.CNT_W(WIDE_W)) uHigh (
         .clk_sys    (clk_sys),
         .reset_n    (reset_n),
         .tick       (hiTick),
         .enable     (enReg[HI] & ~joined),
         .center     (alignReg[HI]),
         .sense      (polReg[SENSE_LSB+HI]),
         .clearCount (cntClear[HI]),
         .perBuf     ({BYTE_ZERO, perReg[HI]}),
         .dutyBuf    ({BYTE_ZERO, dutyReg[HI]}),
         .count      (unitCnt[HI]),
         .wave       (unitWave[HI])
      );

      // Joined counter reads back as high and low bytes
      assign chCount[HI]  = joined ? unitCnt[LO][WIDE_W-1:REG_W] : unitCnt[HI][REG_W-1:0];
      assign chCount[LO]  = unitCnt[LO][REG_W-1:0];
      // Joined output leaves on the high channel's pin, low pin is freed
      assign drive[HI]    = joined ? enReg[LO] : enReg[HI];
      assign driveVal[HI] = joined ? unitWave[LO] : unitWave[HI];
      assign drive[LO]    = ~joined & enReg[LO];
      assign driveVal[LO] = unitWave[LO];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin sharing: an enabled unjoined channel, or a joined pair with its odd channel enabled, wins
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         next_pinOut[i] = drive[i] ? driveVal[i] : gpioOut[i];
         next_pinOe[i]  = drive[i] | gpioDir[i];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pinOut <= '0;
         pinOe  <= '0;
      end else begin
         pinOut <= next_pinOut;
         pinOe  <= next_pinOe;
      end
   end

endmodule : pwc_top

// ===== pwc_checker_props.sv
`timescale 1ns/1ps
module pwc_checker (
   // Clock and reset
   input wire logic                           clk_sys,
   input wire logic                           reset_n,
   // Register bus
   input wire logic [pwc_pkg::ADDR_W-1:0]     address,
   input wire logic                           read,
   input wire logic                           write,
   input wire logic [pwc_pkg::BUS_DATA_W-1:0] writedata,
   input wire logic [3:0]                     byteenable,
   input wire logic [pwc_pkg::BUS_DATA_W-1:0] readdata,
   input wire logic                           waitrequest,
   // Port pins
   input wire logic [pwc_pkg::NUM_CH-1:0]     gpioOut,
   input wire logic [pwc_pkg::NUM_CH-1:0]     gpioDir,
   input wire logic [pwc_pkg::NUM_CH-1:0]     pinOut,
   input wire logic [pwc_pkg::NUM_CH-1:0]     pinOe
);
   import pwc_pkg::*;
   logic [7:0] cfg, pol, next_cfg, next_pol;
   logic [3:0] en, next_en;
   logic       take;
   logic       ans;
   assign take = write && !waitrequest && byteenable[0];
   assign ans  = read && !waitrequest;
   ////////////////////////////////////////////////////////////////
   // Shadow bytes follow landed writes only
   always_comb begin
      next_cfg = (take && address == OFF_CLK) ? writedata[7:0] : cfg;
      next_pol = (take && address == OFF_POL) ? writedata[7:0] : pol;
      next_en  = (take && address == OFF_EN) ? writedata[3:0] : en;
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cfg <= 8'h00;
         pol <= 8'h00;
         en  <= 4'h0;
      end else begin
         cfg <= next_cfg;
         pol <= next_pol;
         en  <= next_en;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Pins settle after two register stages
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sense_read_a: assert property (ans && address == OFF_POL |-> readdata == 32'(pol))
      else $error("sense byte readback");
   pair_read_a: assert property (ans && address == OFF_CLK |-> readdata == 32'(cfg))
      else $error("pairing byte readback");
   enable_read_a: assert property (ans && address == OFF_EN |-> readdata == 32'(en))
      else $error("enable readback");
   gpio_pins_a: assert property ((en == 4'h0)[*3] |-> pinOe == $past(gpioDir) && pinOut == $past(gpioOut))
      else $error("idle pins off port");
   drive_pin_a: assert property ((en[3] && !cfg[7])[*3] |-> pinOe[3])
      else $error("channel lost its pin");
   upper_free_a: assert property (cfg[7][*3] |-> pinOe[3] == $past(gpioDir[3]) && pinOut[3] == $past(gpioOut[3]))
      else $error("ch3 pin not freed");
   lower_free_a: assert property (cfg[6][*3] |-> pinOe[1] == $past(gpioDir[1]) && pinOut[1] == $past(gpioOut[1]))
      else $error("ch1 pin not freed");
   lower_drive_a: assert property ((cfg[6] && en[1])[*3] |-> pinOe[0])
      else $error("joined unit lost ch0 pin");
   cover property (cfg[6] && en[1]);
   cover property (ans && address == OFF_POL && pol != 8'h00);
   cover property (en == 4'hF);
endmodule : pwc_checker
bind pwc_top pwc_checker chk (.clk_sys(clk_sys), .reset_n(reset_n), .address(address),
   .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest), .gpioOut(gpioOut), .gpioDir(gpioDir),
   .pinOut(pinOut), .pinOe(pinOe));

// ===== pwc_top_tb_top.sv
`timescale 1ns/1ps
module pwc_top_tb_top;
   import pwc_pkg::*;
   localparam logic [7:0] DV [5] = '{8'h01, 8'h01, 8'h00, 8'h04, 8'h00};
   localparam logic       PV [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
   localparam int         HV [5] = '{6, 2, 8, 0, 0};
   logic              clk_sys = 1'b0;
   logic              reset_n = 1'b0;
   logic [ADDR_W-1:0] address = 7'h00;
   logic              read = 1'b0;
   logic              write = 1'b0;
   logic [31:0]       writedata;
   logic [3:0]        byteenable = 4'h1;
   logic [3:0]        gpioOut = 4'hA;
   logic [3:0]        gpioDir = 4'h6;
   logic [31:0]       readdata;
   logic              waitrequest;
   logic [3:0]        pinOut;
   logic [3:0]        pinOe;
   logic [31:0]       q;
   int                bad_count = 0;
   int                n_compared = 0;
   int                hi [4];
   int                rise [4];
   always #10 clk_sys = ~clk_sys;
   pwc_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .gpioOut(gpioOut), .gpioDir(gpioDir), .pinOut(pinOut),
      .pinOe(pinOe));
   ////////////////////////////////////////////////////////////////
   // Count a compare, report a difference
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Held until waitrequest is low, then one idle edge
   task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      read      <= !wr;
      write     <= wr;
      address   <= idx;
      writedata <= 32'(d);
      @(posedge clk_sys);
      while (waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 20) bad_count++;
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr
   task automatic rd(input logic [6:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk($sformatf("register %h", idx), q, 32'(e));
   endtask : rd
   // Period, duty, counter clear; channel stopped
   task automatic prep(input logic [6:0] ch, input logic [7:0] per, input logic [7:0] dty);
      wr(OFF_PER0 + ch, per);
      wr(OFF_DUTY0 + ch, dty);
      wr(OFF_CNT0 + ch, 8'h00);
   endtask : prep
   // Whole periods keep counts phase-free
   task automatic meas(input int n);
      logic [3:0] last;
      last = pinOut;
      hi   = '{default: 0};
      rise = '{default: 0};
      repeat (n) begin
         @(posedge clk_sys);
         for (int i = 0; i < 4; i++) begin
            hi[i]   += int'(pinOut[i]);
            rise[i] += int'(pinOut[i] && !last[i]);
         end
         last = pinOut;
      end
   endtask : meas
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #400us;
      bad_count++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      rd(OFF_CLK, 8'h00);
      rd(OFF_POL, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rd(OFF_PER0 + 7'(i), 8'hFF);
         rd(OFF_DUTY0 + 7'(i), 8'hFF);
         rd(OFF_CNT0 + 7'(i), 8'h00);
      end
      wr(OFF_POL, 8'hA5);
      rd(OFF_POL, 8'hA5);
      byteenable <= 4'h0;
      wr(OFF_POL, 8'h3C);
      byteenable <= 4'h1;
      rd(OFF_POL, 8'hA5);
      wr(7'h00, 8'h55);
      rd(7'h00, 8'h00);
      wr(OFF_PRESC, 8'h12);
      rd(OFF_PRESC, 8'h00);
      wr(OFF_POL, 8'h00);
      // Divider sweep: A field d, B field 3-d
      prep(7'h0, 8'h04, 8'h01);
      prep(7'h2, 8'h04, 8'h01);
      for (int d = 0; d < 4; d++) begin
         wr(OFF_EN, 8'h00);
         wr(OFF_CLK, {2'b00, 3'(d), 3'(3 - d)});
         wr(OFF_CNT0, 8'h00);
         wr(OFF_CNT0 + 7'h2, 8'h00);
         wr(OFF_EN, 8'h05);
         repeat (40) @(posedge clk_sys);
         meas(8 << d);
         chk("A edges", rise[0], 2);
         chk("A high", hi[0], 6 << d);
         meas(8 << (3 - d));
         chk("B edges", rise[2], 2);
         chk("pin oe", pinOe, 32'(gpioDir | 4'h5));
      end
      // Sense and duty extremes
      wr(OFF_CLK, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(OFF_EN, 8'h00);
         wr(OFF_POL, {7'h00, PV[k]});
         prep(7'h0, 8'h04, DV[k]);
         wr(OFF_EN, 8'h01);
         repeat (12) @(posedge clk_sys);
         meas(8);
         chk("sense high", hi[0], HV[k]);
      end
      // Scaled clocks on ch1 and ch3
      wr(OFF_EN, 8'h00);
      wr(OFF_POL, 8'hA0);
      wr(OFF_SCALE0, 8'h01);
      wr(OFF_SCALE1, 8'h01);
      for (int c = 0; c < 4; c++) prep(7'(c), 8'h04, 8'h01);
      wr(OFF_EN, 8'h0F);
      repeat (40) @(posedge clk_sys);
      meas(32);
      chk("ch0 edges", rise[0], 8);
      chk("ch1 edges", rise[1], 2);
      chk("ch2 edges", rise[2], 8);
      chk("ch3 edges", rise[3], 2);
      // Both pairs joined, odd enables
      wr(OFF_EN, 8'h00);
      wr(OFF_POL, 8'h00);
      wr(OFF_CLK, 8'hC0);
      prep(7'h0, 8'h00, 8'h00);
      prep(7'h1, 8'h04, 8'h01);
      prep(7'h2, 8'h01, 8'h00);
      prep(7'h3, 8'h00, 8'h02);
      wr(OFF_EN, 8'h0A);
      repeat (600) @(posedge clk_sys);
      meas(512);
      chk("lower edges", rise[0], 128);
      chk("upper high", hi[2], 508);
      chk("upper edges", rise[2], 2);
      chk("joined oe", pinOe, 32'(gpioDir | 4'h5));
      chk("freed pins", pinOut & 4'hA, gpioOut & 4'hA);
      wr(OFF_EN, 8'h00);
      wr(OFF_CNT0 + 7'h3, 8'h5A);
      rd(OFF_CNT0 + 7'h3, 8'h00);
      // Centre aligned: 8 ticks per period
      wr(OFF_CLK, 8'h00);
      wr(OFF_ALIGN, 8'h01);
      prep(7'h0, 8'h04, 8'h02);
      wr(OFF_EN, 8'h01);
      repeat (20) @(posedge clk_sys);
      meas(32);
      chk("centre edges", rise[0], 4);
      chk("centre high", hi[0], 20);
      // Slow clock A: duty write waits, counter write forces it
      wr(OFF_EN, 8'h00);
      wr(OFF_ALIGN, 8'h00);
      wr(OFF_CLK, 8'h38);
      prep(7'h0, 8'h04, 8'h01);
      wr(OFF_EN, 8'h01);
      repeat (260) @(posedge clk_sys);
      wr(OFF_DUTY0, 8'h03);
      repeat (4) @(posedge clk_sys);
      chk("buffered duty", pinOut[0], 1'b1);
      wr(OFF_CNT0, 8'h00);
      repeat (6) @(posedge clk_sys);
      chk("forced load", pinOut[0], 1'b0);
      repeat (200) @(posedge clk_sys);
      chk("new duty held", pinOut[0], 1'b0);
      conclude();
   end
endmodule : pwc_top_tb_top
